// ### shared/cts_defs.vh
// Constants for the trap and operand semantics unit
`ifndef CTS_DEFS_VH
`define CTS_DEFS_VH
`define CTS_STEP_TWO       16'h0002
`define CTS_PC_PLUS_FOUR   16'h0004
`define CTS_PSW_ADDR       16'hFFFE
`define CTS_STACK_PC_ADDR  16'h0000
`define CTS_STACK_PS_ADDR  16'h0002
`define CTS_TBIT           4
`define CTS_PSW_RESET      16'h0000
`define CTS_INIT_NS        10000
`define CTS_PAUSE_NS       90000
`define CTS_CLK_NS         10
`define CTS_INIT_CYC       (`CTS_INIT_NS / `CTS_CLK_NS)
`define CTS_PAUSE_CYC      (`CTS_PAUSE_NS / `CTS_CLK_NS)
`endif

// ### src/cts_trap_unit.v
// Trap sequencing and operand side-effect logic of the processor core
`include "cts_defs.vh"
`default_nettype none

// How it works
// - Same register source and auto-stepped destination: source sees register stepped by two.
// - PC as source with indexed, absolute or deferred destination stores own address plus four.
// - Jump or call through autoincrement uses original register value as new PC.
// - Reset instruction drives bus initialize 10 us, then pauses 90 us.
// - Power fail seen during reset instruction is held until it completes.
// - Return-no-trace setting trace bit traps after the following instruction.
// - Return-from-interrupt setting trace bit traps right after the return.
// - Trace trap is serviced before a concurrent interrupt.
// - Only trap, interrupt entry and returns may change the trace bit.
// - Stack pointer odd or missing address is fatal; new stack built at 0 and 2.
// - Higher pending interrupt is taken before the routine's first instruction.
// - Status word accessible at its address and by move-to and move-from status.
// - Four interrupt request priority levels are supported.
// - Word access to odd address takes odd-address trap.
// - Extended integer and float instructions are never aborted by interrupts.
// - Extended integer source fetch uses a plain read cycle.
// - Word move's final access is a write cycle only.
// - Instruction fetch bus error leaves PC already incremented.
// - Autoincrement bus error leaves the register incremented.
module cts_trap_unit #(
    parameter INIT_CYC  = `CTS_INIT_CYC,
    parameter PAUSE_CYC = `CTS_PAUSE_CYC
) (
    input  wire        clk,            // Processor clock
    input  wire        rst_n,          // Asynchronous reset, active low
    input  wire [15:0] src_reg_val,    // Current value of the shared register
    input  wire        same_reg,       // Source and destination use one register
    input  wire        dst_autoinc,    // Destination mode autoincrement (direct or deferred)
    input  wire        dst_autodec,    // Destination mode autodecrement (direct or deferred)
    output reg  [15:0] src_operand,    // Source operand as read
    input  wire [15:0] instr_addr,     // Address of current instruction
    input  wire        pc_src_ixdef,   // PC source with indexed/absolute/deferred dest
    output reg  [15:0] pc_store_val,   // Value stored for PC-as-source
    input  wire        jump_autoinc,   // Jump or call through (R)+
    input  wire [15:0] jump_reg_val,   // Register value for jump target
    output reg  [15:0] jump_target,    // New PC for jump
    output reg  [15:0] jump_reg_next,  // Register after the jump
    input  wire        reset_instr,    // Start system reset instruction (pulse)
    output reg         bus_init,       // Bus initialize
    output wire        reset_busy,     // Reset instruction in progress
    input  wire        power_fail,     // Power fail condition
    output reg         power_fail_req, // Power fail recognised
    input  wire        instr_done,     // Instruction completed (pulse)
    input  wire        ret_intr,       // Return-from-interrupt completes (pulse)
    input  wire        ret_no_trace,   // Return-no-trace completes (pulse)
    input  wire [15:0] ret_psw,        // Status popped by a return
    input  wire        move_to_status, // Move-to-status write (pulse)
    input  wire        psw_mem_wr,     // Write to status word address (pulse)
    input  wire        console_dep,    // Console deposit to status (pulse)
    input  wire [15:0] wr_data,        // Data for explicit status write
    output reg  [15:0] processor_status_word, // Current status
    output wire [15:0] move_from_status,      // Status read value
    input  wire [15:0] mem_rd_addr,    // Address of a read probe
    output wire        psw_hit,        // Probe hits status address
    input  wire [3:0]  irq,            // Interrupt requests, levels 4..7
    input  wire        first_instr,    // Next instruction is a routine's first
    input  wire        long_instr,     // Extended integer or float instruction busy
    output reg         trap_req,       // Take a trap or interrupt now
    output reg  [1:0]  trap_kind,      // 0 trace,1 intr,2 odd,3 bus error
    output reg  [1:0]  irq_level,      // Level taken
    input  wire        word_access,    // Word access in progress
    input  wire        access_odd,     // Address bit 0 set
    input  wire        bus_error,      // Nonexistent address timeout
    input  wire        via_sp,         // Access through stack pointer
    input  wire        in_trap_svc,    // Trap service in progress
    output reg         fatal_trap,     // Fatal stack trap
    output reg  [15:0] new_sp,         // Stack pointer to use for the push
    input  wire        eis_src_fetch,  // Extended integer source fetch
    input  wire        move_last,      // Word move final access
    output reg  [1:0]  bus_cycle,      // 0 none,1 read,2 read-pause,3 write
    input  wire        fetch_cycle,    // Instruction fetch in progress
    input  wire [15:0] pc_val,         // PC before fetch
    output reg  [15:0] pc_after_err,   // PC after a fetch bus error
    input  wire        mode2_access,   // Autoincrement access
    output reg  [15:0] reg_after_err,  // Register after mode-2 bus error
    input  wire        trap_enter,     // Begin trap entry (pulse)
    input  wire [15:0] vec_pc,         // Vector new PC
    input  wire [15:0] vec_psw,        // Vector new status
    input  wire [15:0] cur_pc,         // PC to push
    output reg  [15:0] push_pc,        // Pushed PC word
    output reg  [15:0] push_psw,       // Pushed status word
    output reg  [15:0] load_pc         // PC loaded from vector
);
    localparam CNT_W = 16;
    localparam RS_IDLE = 2'd0;
    localparam RS_INIT = 2'd1;
    localparam RS_PAUSE = 2'd2;

    reg  [1:0]       rst_state;
    reg  [CNT_W-1:0] rst_cnt;
    reg              pf_held;
    reg              trace_pend;
    reg              trace_delay;
    wire             tbit = processor_status_word[`CTS_TBIT];

    // Operand side effects, combinational paths
    always @*
    begin
        src_operand = src_reg_val;
        if (same_reg && dst_autoinc)
            src_operand = src_reg_val + `CTS_STEP_TWO;
        else if (same_reg && dst_autodec)
            src_operand = src_reg_val - `CTS_STEP_TWO;
        pc_store_val = pc_src_ixdef ? instr_addr + `CTS_PC_PLUS_FOUR : instr_addr;
        jump_target   = jump_reg_val;
        jump_reg_next = jump_autoinc ? jump_reg_val + `CTS_STEP_TWO : jump_reg_val;
        pc_after_err  = fetch_cycle ? pc_val + `CTS_STEP_TWO : pc_val;
        reg_after_err = mode2_access ? src_reg_val + `CTS_STEP_TWO : src_reg_val;
        // Plain read for extended source, write-only for word move end
        if (move_last)
            bus_cycle = 2'd3;
        else if (eis_src_fetch)
            bus_cycle = 2'd1;
        else
            bus_cycle = 2'd0;
    end

    assign move_from_status = processor_status_word;
    assign psw_hit = (mem_rd_addr == `CTS_PSW_ADDR);
    assign reset_busy = (rst_state != RS_IDLE);

    // Reset instruction sequencer; counter width bounds the longest phase
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_state <= RS_IDLE;
            rst_cnt   <= 16'h0000;
            bus_init  <= 1'b0;
        end
        else
        begin
            case (rst_state)
                RS_IDLE:
                begin
                    if (reset_instr)
                    begin
                        rst_state <= RS_INIT;
                        rst_cnt   <= INIT_CYC[CNT_W-1:0] - 16'h0001;
                        bus_init  <= 1'b1;
                    end
                end
                RS_INIT:
                begin
                    if (rst_cnt == 16'h0000)
                    begin
                        rst_state <= RS_PAUSE;
                        rst_cnt   <= PAUSE_CYC[CNT_W-1:0] - 16'h0001;
                        bus_init  <= 1'b0;
                    end
                    else
                        rst_cnt <= rst_cnt - 16'h0001;
                end
                RS_PAUSE:
                begin
                    if (rst_cnt == 16'h0000)
                        rst_state <= RS_IDLE;
                    else
                        rst_cnt <= rst_cnt - 16'h0001;
                end
                default:
                begin
                    rst_state <= RS_IDLE;
                    bus_init  <= 1'b0;
                end
            endcase
        end
    end

    // Power fail is latched while reset runs so it cannot cut the pause short
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pf_held        <= 1'b0;
            power_fail_req <= 1'b0;
        end
        else
        begin
            pf_held        <= reset_busy & (pf_held | power_fail);
            power_fail_req <= ~reset_busy & (power_fail | pf_held);
        end
    end

    // Status word: explicit writes touch all bits but the trace bit
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            processor_status_word <= `CTS_PSW_RESET;
        else if (trap_enter)
            processor_status_word <= vec_psw;
        else if (ret_intr || ret_no_trace)
            processor_status_word <= ret_psw;
        else if (move_to_status || psw_mem_wr || console_dep)
        begin
            processor_status_word <= wr_data;
            processor_status_word[`CTS_TBIT] <= tbit;
        end
    end

    // Trace scheduling: return-no-trace defers one instruction
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trace_pend  <= 1'b0;
            trace_delay <= 1'b0;
        end
        else if (trap_enter)
        begin
            trace_pend  <= 1'b0;
            trace_delay <= 1'b0;
        end
        else if (ret_no_trace)
        begin
            trace_pend  <= 1'b0;
            trace_delay <= ret_psw[`CTS_TBIT];
        end
        else if (ret_intr)
            trace_pend <= ret_psw[`CTS_TBIT];
        else if (instr_done)
        begin
            trace_pend  <= tbit | trace_delay;
            trace_delay <= 1'b0;
        end
    end

    // Trap arbitration; stack faults first, then odd-address and bus errors, then trace, then interrupts
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trap_req   <= 1'b0;
            trap_kind  <= 2'd0;
            irq_level  <= 2'd0;
            fatal_trap <= 1'b0;
            new_sp     <= 16'h0000;
        end
        else
        begin
            trap_req   <= 1'b0;
            fatal_trap <= 1'b0;
            if ((bus_error || (word_access && access_odd)) && via_sp)
            begin
                trap_req   <= 1'b1;
                fatal_trap <= 1'b1;
                trap_kind  <= 2'd3;
                new_sp     <= `CTS_STACK_PS_ADDR + `CTS_STEP_TWO;
            end
            else if (bus_error && in_trap_svc)
            begin
                trap_req  <= 1'b1;
                trap_kind <= 2'd3;
                new_sp    <= `CTS_STACK_PS_ADDR + `CTS_STEP_TWO;
            end
            else if (word_access && access_odd)
            begin
                trap_req  <= 1'b1;
                trap_kind <= 2'd2;
            end
            else if (bus_error)
            begin
                trap_req  <= 1'b1;
                trap_kind <= 2'd3;
            end
            else if (trace_pend && !long_instr)
            begin
                trap_req  <= 1'b1;
                trap_kind <= 2'd0;
            end
            // A trace owed by the finishing instruction goes first; the request waits
            else if (irq != 4'h0 && !long_instr && (instr_done || first_instr)
                     && !(instr_done && (tbit || trace_delay)))
            begin
                trap_req  <= 1'b1;
                trap_kind <= 2'd1;
                irq_level <= irq[3] ? 2'd3 : irq[2] ? 2'd2 : irq[1] ? 2'd1 : 2'd0;
            end
        end
    end

    // Trap entry: push old status and PC, load new pair from vector
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            push_pc  <= 16'h0000;
            push_psw <= 16'h0000;
            load_pc  <= 16'h0000;
        end
        else if (trap_enter)
        begin
            push_psw <= processor_status_word;
            push_pc  <= cur_pc;
            load_pc  <= vec_pc;
        end
    end
endmodule

`default_nettype wire

// ### tb/cts_bus_model.sv
// Behavioural stand-in for memory and devices on the system bus
`default_nettype none
module cts_bus_model #(
    parameter MEM_TOP = 16'h8000
) (
    input  wire logic [15:0] addr, // Bus address
    input  wire logic        req,  // Access in progress
    output logic             nxm,  // No device answers
    output logic             odd   // Odd byte address
);
    timeunit 1ns;
    timeprecision 1ps;
    // Nothing answers at or above MEM_TOP, so those accesses time out
    assign nxm = req && (addr >= MEM_TOP);
    assign odd = req && addr[0];
endmodule
`default_nettype wire

// ### tb/cts_trap_checker.sv
// Assertion checker for the trap and operand unit
`default_nettype none
module cts_trap_checker #(
    parameter INIT_CYC  = 5,
    parameter PAUSE_CYC = 10
) (
    input wire logic        clk, rst_n, same_reg, dst_autoinc, dst_autodec, // Modes
    input wire logic        pc_src_ixdef, jump_autoinc, fetch_cycle,        // Modes
    input wire logic [15:0] src_reg_val, src_operand, instr_addr,           // Operands
    input wire logic [15:0] pc_store_val, jump_reg_val, jump_target,        // Operands
    input wire logic [15:0] jump_reg_next, pc_val, pc_after_err, new_sp,    // Results
    input wire logic [15:0] ret_psw, processor_status_word, move_from_status, // Status
    input wire logic [15:0] cur_pc, push_pc,                                // Push
    input wire logic        reset_instr, bus_init, reset_busy, power_fail_req, // Reset
    input wire logic        move_to_status, psw_mem_wr, console_dep,        // Writes
    input wire logic        ret_intr, trap_enter, long_instr, trap_req,     // Traps
    input wire logic        ret_no_trace, instr_done,                       // Pops
    input wire logic [3:0]  irq,                                            // Requests
    input wire logic        word_access, access_odd, via_sp, in_trap_svc,   // Access
    input wire logic        bus_error, fatal_trap, eis_src_fetch, move_last, // Faults
    input wire logic [1:0]  trap_kind, bus_cycle                            // Codes
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Bus init phase, then the pause; counts match the bench parameters
    sequence s_init;
        bus_init [*5] ##1 !bus_init;
    endsequence
    sequence s_busy;
        reset_busy [*8] ##1 reset_busy [*7] ##1 !reset_busy;
    endsequence
    a_init_span: assert property (reset_instr && !reset_busy |=> s_init)
        else $error("init width wrong");
    a_busy_span: assert property (reset_instr && !reset_busy |=> s_busy)
        else $error("reset pause wrong");
    a_pf_defer: assert property ($rose(power_fail_req) |-> !$past(reset_busy))
        else $error("power fail seen early");
    a_trace_keep: assert property ((move_to_status || psw_mem_wr || console_dep)
        && !trap_enter && !ret_intr && !ret_no_trace |=> $stable(processor_status_word[4]))
        else $error("trace bit written");
    a_trace_first: assert property (instr_done && processor_status_word[4] && irq != 4'h0
        |=> !(trap_req && trap_kind == 2'h1))
        else $error("interrupt beat trace");
    a_status_read: assert property (move_from_status == processor_status_word)
        else $error("status read differs");
    a_src_step: assert property (same_reg && (dst_autoinc || dst_autodec) |->
        src_operand == (dst_autoinc ? src_reg_val + 16'h0002 : src_reg_val - 16'h0002))
        else $error("source not stepped");
    a_pc_four: assert property (pc_src_ixdef |-> pc_store_val == instr_addr + 16'h0004)
        else $error("stored pc wrong");
    a_jump_orig: assert property (jump_autoinc |-> jump_target == jump_reg_val)
        else $error("jump target stepped");
    a_long_noint: assert property (long_instr |=> !(trap_req && trap_kind == 2'h1))
        else $error("long instruction interrupted");
    a_odd_trap: assert property (word_access && access_odd && !via_sp && !in_trap_svc
        |=> trap_req && trap_kind == 2'h2)
        else $error("odd trap missing");
    a_stack_fatal: assert property (via_sp && (word_access && access_odd || bus_error)
        |=> fatal_trap && new_sp == 16'h0004)
        else $error("stack fault missing");
    a_eis_read: assert property (eis_src_fetch |-> bus_cycle == 2'h1)
        else $error("eis fetch not plain read");
    a_move_write: assert property (move_last && !eis_src_fetch |-> bus_cycle == 2'h3)
        else $error("move not write only");
    a_fetch_err: assert property (fetch_cycle && bus_error |->
        pc_after_err == pc_val + 16'h0002)
        else $error("fetch error pc wrong");
    a_trap_push: assert property (trap_enter |=> push_pc == $past(cur_pc))
        else $error("pushed pc wrong");
    a_rti_trace: assert property (ret_intr && ret_psw[4] && !long_instr |->
        ##[1:3] trap_req && trap_kind == 2'h0)
        else $error("trace after return late");
endmodule
bind cts_trap_unit cts_trap_checker #(.INIT_CYC(INIT_CYC), .PAUSE_CYC(PAUSE_CYC)) u_chk (.*);
`default_nettype wire

// ### tb/test_cts_trap_unit.sv
// Self-checking bench for the trap and operand unit
`default_nettype none
module test_cts_trap_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, same_reg = 0, dst_autoinc = 0, dst_autodec = 0, pc_src_ixdef = 0;
    logic jump_autoinc = 0, reset_instr = 0, power_fail = 0, instr_done = 0, ret_intr = 0;
    logic ret_no_trace = 0, move_to_status = 0, psw_mem_wr = 0, console_dep = 0, first_instr = 0;
    logic long_instr = 0, word_access = 0, via_sp = 0, in_trap_svc = 0, eis_src_fetch = 0;
    logic move_last = 0, fetch_cycle = 0, mode2_access = 0, trap_enter = 0, bus_req = 0;
    logic [15:0] src_reg_val = 0, instr_addr = 0, jump_reg_val = 0, ret_psw = 0, wr_data = 0;
    logic [15:0] mem_rd_addr = 0, pc_val = 0, vec_pc = 0, vec_psw = 0, cur_pc = 0, bus_addr = 0;
    logic [3:0]  irq = 0;
    wire logic bus_error, access_odd, bus_init, reset_busy, power_fail_req, psw_hit, trap_req;
    wire logic fatal_trap;
    wire logic [1:0]  trap_kind, irq_level, bus_cycle;
    wire logic [15:0] src_operand, pc_store_val, jump_target, jump_reg_next, new_sp, push_pc;
    wire logic [15:0] processor_status_word, move_from_status, pc_after_err, reg_after_err;
    wire logic [15:0] push_psw, load_pc;
    integer n_errors = 0, tests_run = 0, seed = 40885, k, got, busy;
    logic [1:0] exp_q[$];
    cts_trap_unit #(.INIT_CYC(5), .PAUSE_CYC(10)) i_dut (.*);
    cts_bus_model i_bus (.addr(bus_addr), .req(bus_req), .nxm(bus_error), .odd(access_odd));
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_val({15'h0000, g}, {15'h0000, e});
    endtask
    // Waits a bounded time for a trap pulse, then checks its kind
    task automatic wait_trap(input logic [1:0] kind);
        for (int i = 0; i < 4 && trap_req !== 1'b1; i++)
            @(negedge clk);
        chk_val({13'h0000, trap_req, trap_kind}, {13'h0000, 1'b1, kind});
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        forever #5 clk = ~clk;
    end
    // Watchdog: the run needs well under ten thousand cycles
    initial
    begin
        #100000;
        n_errors++;
        print_verdict;
    end
    initial
    begin
        repeat (20) @(negedge clk);
        rst_n = 1;
        // Random operands; missing memory at and above 16'h8000 makes fetch errors
        for (k = 0; k < 40; k++)
        begin
            @(negedge clk);
            {src_reg_val, instr_addr, jump_reg_val, pc_val} = {$random(seed), $random(seed)};
            mem_rd_addr = k[0] ? 16'hFFFE : 16'h0100;
            {same_reg, dst_autoinc, dst_autodec} = {1'b1, k[0], !k[0]};
            {pc_src_ixdef, jump_autoinc, fetch_cycle, bus_req, mode2_access} = 5'h1F;
            bus_addr = 16'h8000 | k[15:0] << 1;
            #1;
            chk_val(src_operand, k[0] ? src_reg_val + 16'h0002 : src_reg_val - 16'h0002);
            chk_val(pc_store_val, instr_addr + 16'h0004);
            chk_val(jump_target, jump_reg_val);
            chk_val(jump_reg_next, jump_reg_val + 16'h0002);
            chk_val(reg_after_err, src_reg_val + 16'h0002);
            chk_val(pc_after_err, pc_val + 16'h0002);
            chk_bit(psw_hit, k[0]);
        end
        {same_reg, pc_src_ixdef, jump_autoinc, fetch_cycle, bus_req, mode2_access} = 6'h00;
        // Every request level, one at a time
        for (k = 0; k < 4; k++)
        begin
            {irq, instr_done} = {4'h1 << k, 1'b1};
            @(negedge clk);
            {irq, instr_done} = 5'h00;
            wait_trap(2'h1);
            chk_val({14'h0000, irq_level}, k[15:0]);
        end
        {long_instr, irq, instr_done} = {1'b1, 4'h8, 1'b1};
        repeat (3) @(negedge clk) chk_bit(trap_req, 1'b0);
        {long_instr, instr_done, irq, first_instr} = {2'b00, 4'hC, 1'b1};
        @(negedge clk);
        {irq, first_instr} = 5'h00;
        wait_trap(2'h1);
        chk_val({14'h0000, irq_level}, 16'h0003);
        // Explicit status writes try to set the trace bit
        wr_data = 16'h0010;
        for (k = 0; k < 3; k++)
        begin
            {move_to_status, psw_mem_wr, console_dep} = 3'b100 >> k;
            @(negedge clk);
            {move_to_status, psw_mem_wr, console_dep} = 3'b000;
            chk_bit(processor_status_word[4], 1'b0);
        end
        // Return sets trace; trace then beats a pending interrupt
        exp_q = '{2'h0, 2'h0};
        {ret_psw, ret_intr} = {16'h0010, 1'b1};
        @(negedge clk);
        ret_intr = 0;
        wait_trap(exp_q.pop_front());
        chk_val(processor_status_word, ret_psw);
        @(negedge clk);
        {irq, instr_done} = 5'h03;
        @(negedge clk);
        {irq, instr_done} = 5'h00;
        wait_trap(exp_q.pop_front());
        {cur_pc, vec_pc, vec_psw, trap_enter} = {16'h1234, 16'h0400, 16'h0000, 1'b1};
        @(negedge clk);
        trap_enter = 0;
        chk_val(push_pc, cur_pc);
        chk_val(push_psw, ret_psw);
        chk_val(load_pc, vec_pc);
        chk_val(processor_status_word, vec_psw);
        // Return without trace: trap only after the next instruction
        ret_no_trace = 1;
        @(negedge clk);
        ret_no_trace = 0;
        repeat (3) @(negedge clk) chk_bit(trap_req, 1'b0);
        instr_done = 1;
        @(negedge clk);
        instr_done = 0;
        wait_trap(2'h0);
        {ret_psw, ret_no_trace} = 17'h0_0001;
        @(negedge clk);
        ret_no_trace = 0;
        // Odd word access, then odd and missing addresses through the stack
        for (k = 0; k < 3; k++)
        begin
            {bus_req, word_access, via_sp} = {2'b11, k > 0};
            bus_addr = (k == 2) ? 16'h9000 : 16'h0101;
            @(negedge clk);
            {bus_req, word_access, via_sp} = 3'b000;
            if (k == 0)
                wait_trap(2'h2);
            else
                chk_val({15'h0000, fatal_trap} | new_sp, 16'h0005);
        end
        // Missing address while a trap is being serviced: plain bus error trap
        {bus_req, in_trap_svc, bus_addr} = {2'b11, 16'h9000};
        @(negedge clk);
        {bus_req, in_trap_svc} = 2'b00;
        chk_val({12'h000, trap_req, fatal_trap, trap_kind}, 16'h000B);
        {eis_src_fetch, move_last} = 2'b10;
        #1 chk_val({14'h0000, bus_cycle}, 16'h0001);
        {eis_src_fetch, move_last} = 2'b01;
        #1 chk_val({14'h0000, bus_cycle}, 16'h0003);
        move_last = 0;
        // Reset instruction with power failing from the cycle after it starts
        @(negedge clk);
        reset_instr = 1;
        @(negedge clk);
        {reset_instr, got, busy} = 0;
        power_fail = 1; // Rises once the reset instruction is under way
        for (k = 0; k < 30; k++)
        begin
            got += bus_init;
            busy += reset_busy;
            if (reset_busy === 1'b1)
                chk_bit(power_fail_req, 1'b0);
            @(negedge clk);
        end
        chk_val(got[15:0], 16'h0005);
        chk_val(busy[15:0], 16'h000F);
        chk_bit(power_fail_req, 1'b1);
        print_verdict;
    end
endmodule
`default_nettype wire
